/* prl_maint.sv */
// Performance report source and maintenance loopback control with APB registers
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module prl_maint #(
    parameter int ACT_LEN = 5,
    parameter logic [15:0] ACT_CODE = 16'h0001,
    parameter int DEACT_LEN = 3,
    parameter logic [15:0] DEACT_CODE = 16'h0001,
    parameter int PAY_LEN = 6,
    parameter logic [15:0] PAY_CODE = 16'h0003,
    parameter int AIS_LEN = 1,
    parameter int CW_HITS = 64,
    parameter int AIS_HITS = 256
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [prl_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [prl_pkg::DATA_W-1:0] pwdata,
    output logic [prl_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic bit_stb,
    input wire logic rx_bit,
    input wire logic rx_fbit,
    input wire logic loc_bit,
    output logic line_tx_bit,
    output logic fwd_bit,
    input wire logic dl_req,
    output logic dl_bit,
    input wire logic dl_rx_valid,
    input wire logic dl_rx_bit,
    input wire logic one_sec,
    output logic line_loop,
    output logic payload_loop
);
    generate
        if (CW_HITS < 1 || AIS_HITS < 1) begin : g_bad
            $error("prl_maint detection counts must be positive");
        end
    endgenerate

    logic [prl_pkg::CTRL_W-1:0] ctrl_r;
    logic [prl_pkg::RPT_W-1:0] rpt_r;
    logic [prl_pkg::INT_W-1:0] ist_r;
    logic [prl_pkg::INT_W-1:0] imask_r;
    logic [prl_pkg::INT_W-1:0] ev;
    logic [prl_pkg::DATA_W-1:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic irq_r;
    logic wr_acc;
    logic acc;
    logic mapped;

    // Register bus: answer in the second access cycle
    assign acc = psel && penable && !pready_r;
    assign wr_acc = psel && penable && pready_r && pwrite;
    assign mapped = (paddr == prl_pkg::OFF_CTRL) || (paddr == prl_pkg::OFF_STATUS) ||
        (paddr == prl_pkg::OFF_REPORT) || (paddr == prl_pkg::OFF_INT_STAT) ||
        (paddr == prl_pkg::OFF_INT_MASK);

    // Codeword detectors on the received line stream
    prl_cw_if act_if ();
    prl_cw_if deact_if ();
    prl_cw_if pay_if ();
    prl_cw_if ais_if ();
    assign act_if.bit_v = bit_stb;
    assign act_if.bit_d = rx_bit;
    assign deact_if.bit_v = bit_stb;
    assign deact_if.bit_d = rx_bit;
    assign pay_if.bit_v = bit_stb;
    assign pay_if.bit_d = rx_bit;
    assign ais_if.bit_v = bit_stb;
    assign ais_if.bit_d = rx_bit;

    prl_cw_detect #(.LEN(ACT_LEN), .CODE(ACT_CODE), .HITS(CW_HITS)) u_act (
        .clock(clock), .rstn(rstn), .cw(act_if.det));
    prl_cw_detect #(.LEN(DEACT_LEN), .CODE(DEACT_CODE), .HITS(CW_HITS)) u_deact (
        .clock(clock), .rstn(rstn), .cw(deact_if.det));
    prl_cw_detect #(.LEN(PAY_LEN), .CODE(PAY_CODE), .HITS(CW_HITS)) u_pay (
        .clock(clock), .rstn(rstn), .cw(pay_if.det));
    prl_cw_detect #(.LEN(AIS_LEN), .CODE(16'h0001), .HITS(AIS_HITS)) u_ais (
        .clock(clock), .rstn(rstn), .cw(ais_if.det));

    // Data link watch for two reports split by unbroken flag idle
    logic [7:0] dl_sh_r;
    logic [7:0] dl_cnt_r;
    logic dl_seen_r;
    logic dl_rel;
    logic dl_flag;
    logic dl_abort;
    logic dl_rpt;
    assign dl_flag = dl_rx_valid && ({dl_rx_bit, dl_sh_r[7:1]} == prl_pkg::FLAG_PAT);
    assign dl_abort = dl_rx_valid && (dl_sh_r[7:1] == 7'h7F) && dl_rx_bit;
    assign dl_rpt = (dl_cnt_r >= prl_pkg::RPT_GAP_MIN - 8'h01) &&
        (dl_cnt_r <= prl_pkg::RPT_GAP_MAX - 8'h01);

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            dl_sh_r <= 8'h00;
            dl_cnt_r <= 8'h00;
            dl_seen_r <= 1'b0;
        end else if (dl_rx_valid) begin
            dl_sh_r <= {dl_rx_bit, dl_sh_r[7:1]};
            if (dl_flag) begin
                dl_cnt_r <= 8'h00;
                if (dl_rpt) begin
                    dl_seen_r <= 1'b1;
                end else if (dl_cnt_r != prl_pkg::IDLE_GAP - 8'h01) begin
                    dl_seen_r <= 1'b0;
                end
            end else begin
                if (dl_cnt_r != 8'hFF) begin
                    dl_cnt_r <= dl_cnt_r + 8'h01;
                end
                if (dl_abort) begin
                    dl_seen_r <= 1'b0;
                end
            end
        end
    end
    assign dl_rel = dl_flag && dl_rpt && dl_seen_r;

    // Loopback state; software arms the options and disarming drops them, codewords switch them on, codewords or two link reports switch them off
    prl_pkg::prl_lp_e line_st_r;
    prl_pkg::prl_lp_e pay_st_r;
    logic release_ev;
    assign release_ev = deact_if.hit || ais_if.hit || dl_rel;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            line_st_r <= prl_pkg::PRL_LP_OFF;
        end else if (release_ev || !ctrl_r[prl_pkg::CTRL_LINE_EN]) begin
            line_st_r <= prl_pkg::PRL_LP_OFF;
        end else begin
            unique case (line_st_r)
                prl_pkg::PRL_LP_OFF: begin
                    if (act_if.hit && pay_st_r == prl_pkg::PRL_LP_OFF) begin
                        line_st_r <= prl_pkg::PRL_LP_PREP;
                    end
                end
                prl_pkg::PRL_LP_PREP: begin
                    if (!act_if.hit) begin
                        line_st_r <= prl_pkg::PRL_LP_ON;
                    end
                end
                prl_pkg::PRL_LP_ON: begin
                    line_st_r <= prl_pkg::PRL_LP_ON;
                end
            endcase
        end
    end

    // Payload loop exists only where this end terminates framing
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pay_st_r <= prl_pkg::PRL_LP_OFF;
        end else if (release_ev || !ctrl_r[prl_pkg::CTRL_PAY_EN]) begin
            pay_st_r <= prl_pkg::PRL_LP_OFF;
        end else begin
            unique case (pay_st_r)
                prl_pkg::PRL_LP_OFF: begin
                    if (pay_if.hit && line_st_r == prl_pkg::PRL_LP_OFF) begin
                        pay_st_r <= prl_pkg::PRL_LP_PREP;
                    end
                end
                prl_pkg::PRL_LP_PREP: begin
                    if (!pay_if.hit) begin
                        pay_st_r <= prl_pkg::PRL_LP_ON;
                    end
                end
                prl_pkg::PRL_LP_ON: begin
                    pay_st_r <= prl_pkg::PRL_LP_ON;
                end
            endcase
        end
    end

    logic line_on;
    logic pay_on;
    assign line_on = line_st_r == prl_pkg::PRL_LP_ON;
    assign pay_on = pay_st_r == prl_pkg::PRL_LP_ON;

    // Line data path, one bit per strobe
    logic line_tx_r;
    logic fwd_r;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            line_tx_r <= 1'b1;
            fwd_r <= 1'b1;
        end else if (bit_stb) begin
            if (line_on) begin
                line_tx_r <= rx_bit;
                fwd_r <= 1'b1;
            end else if (pay_on) begin
                // Local framing bit replaces the looped one
                line_tx_r <= rx_fbit ? loc_bit : rx_bit;
                fwd_r <= rx_bit;
            end else begin
                line_tx_r <= loc_bit;
                fwd_r <= rx_bit;
            end
        end
    end

    // Report history: current second and the three before it
    logic [prl_pkg::RPT_W-1:0] hist_r [4];
    logic [1:0] nmod_r;
    logic pend_r;
    logic [prl_pkg::RPT_W-1:0] rpt_word;
    logic sent_ev;
    always_comb begin
        rpt_word = rpt_r;
        rpt_word[prl_pkg::RPT_LB_POS] = pay_on;
        rpt_word[prl_pkg::RPT_N_LO +: 2] = nmod_r;
    end

    prl_pkg::prl_tx_e tx_st_r;
    logic [3:0] oct_idx_r;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 4; i++) begin
                hist_r[i] <= prl_pkg::RPT_RESET;
            end
            nmod_r <= 2'h0;
        end else if (one_sec && ctrl_r[prl_pkg::CTRL_RPT_EN] && tx_st_r ==
            prl_pkg::PRL_TX_FLAG) begin
            hist_r[0] <= rpt_word;
            for (int i = 1; i < 4; i++) begin
                hist_r[i] <= hist_r[i-1];
            end
            nmod_r <= nmod_r + 2'h1;
        end
    end

    // Octets of the frame as sent, least significant bit first; word low byte leads
    logic [7:0] cur_oct;
    logic [1:0] word_sel;
    always_comb begin
        word_sel = 2'((oct_idx_r - 4'h3) >> 1);
        unique case (oct_idx_r)
            4'h0: cur_oct = {prl_pkg::SERVICE_POINT_ID_VAL, ctrl_r[prl_pkg::CTRL_SRC_SIDE], 1'b0};
            4'h1: cur_oct = {6'h00, ctrl_r[prl_pkg::CTRL_SECTION], 1'b1};
            4'h2: cur_oct = prl_pkg::CTL_UI;
            default: cur_oct = oct_idx_r[0] ? hist_r[word_sel][7:0] : hist_r[word_sel][15:8];
        endcase
    end

    // Data link transmitter: flags when idle, report once per second
    logic [2:0] bit_idx_r;
    logic [3:0] fcs_idx_r;
    logic [2:0] ones_r;
    logic [15:0] crc_r;
    logic dl_r;
    logic cur_bit;
    logic [15:0] crc_nxt;
    assign cur_bit = cur_oct[bit_idx_r];
    assign crc_nxt = (crc_r >> 1) ^ ((crc_r[0] ^ cur_bit) ? prl_pkg::CRC_POLY : 16'h0000);

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pend_r <= 1'b0;
        end else if (one_sec && ctrl_r[prl_pkg::CTRL_RPT_EN] &&
            tx_st_r == prl_pkg::PRL_TX_FLAG) begin
            pend_r <= 1'b1;
        end else if (dl_req && tx_st_r == prl_pkg::PRL_TX_FLAG && bit_idx_r == 3'h7) begin
            pend_r <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            tx_st_r <= prl_pkg::PRL_TX_FLAG;
            bit_idx_r <= 3'h0;
            oct_idx_r <= 4'h0;
            fcs_idx_r <= 4'h0;
            ones_r <= 3'h0;
            crc_r <= prl_pkg::CRC_INIT;
            dl_r <= 1'b0;
        end else if (dl_req) begin
            unique case (tx_st_r)
                prl_pkg::PRL_TX_FLAG: begin
                    dl_r <= prl_pkg::FLAG_PAT[bit_idx_r];
                    bit_idx_r <= bit_idx_r + 3'h1;
                    ones_r <= 3'h0;
                    oct_idx_r <= 4'h0;
                    fcs_idx_r <= 4'h0;
                    crc_r <= prl_pkg::CRC_INIT;
                    if (bit_idx_r == 3'h7 && pend_r) begin
                        tx_st_r <= prl_pkg::PRL_TX_BODY;
                    end
                end
                prl_pkg::PRL_TX_BODY: begin
                    if (ones_r == 3'(prl_pkg::STUFF_RUN)) begin
                        dl_r <= 1'b0;
                        ones_r <= 3'h0;
                    end else begin
                        dl_r <= cur_bit;
                        ones_r <= cur_bit ? ones_r + 3'h1 : 3'h0;
                        crc_r <= crc_nxt;
                        bit_idx_r <= bit_idx_r + 3'h1;
                        if (bit_idx_r == 3'h7) begin
                            oct_idx_r <= oct_idx_r + 4'h1;
                            // Opening flag is the first of the fixed-length octets
                            if (oct_idx_r == 4'(prl_pkg::RPT_OCTETS - 2)) begin
                                tx_st_r <= prl_pkg::PRL_TX_FCS;
                            end
                        end
                    end
                end
                prl_pkg::PRL_TX_FCS: begin
                    if (ones_r == 3'(prl_pkg::STUFF_RUN)) begin
                        dl_r <= 1'b0;
                        ones_r <= 3'h0;
                    end else begin
                        dl_r <= ~crc_r[fcs_idx_r];
                        ones_r <= !crc_r[fcs_idx_r] ? ones_r + 3'h1 : 3'h0;
                        fcs_idx_r <= fcs_idx_r + 4'h1;
                        if (fcs_idx_r == 4'hF) begin
                            tx_st_r <= prl_pkg::PRL_TX_FLAG;
                            bit_idx_r <= 3'h0;
                        end
                    end
                end
                default: begin
                    tx_st_r <= prl_pkg::PRL_TX_FLAG;
                end
            endcase
        end
    end
    assign sent_ev = dl_req && tx_st_r == prl_pkg::PRL_TX_FCS && fcs_idx_r == 4'hF &&
        ones_r != 3'(prl_pkg::STUFF_RUN);

    // Interrupt events
    always_comb begin
        ev = '0;
        ev[prl_pkg::INT_LINE_UP] = line_st_r == prl_pkg::PRL_LP_PREP && !act_if.hit &&
            !release_ev && ctrl_r[prl_pkg::CTRL_LINE_EN];
        ev[prl_pkg::INT_PAY_UP] = pay_st_r == prl_pkg::PRL_LP_PREP && !pay_if.hit &&
            !release_ev && ctrl_r[prl_pkg::CTRL_PAY_EN];
        ev[prl_pkg::INT_RELEASE] = release_ev && (line_on || pay_on);
        ev[prl_pkg::INT_SENT] = sent_ev;
    end

    // Registers; a new event wins over a write-one clear
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= prl_pkg::CTRL_RESET;
            rpt_r <= prl_pkg::RPT_RESET;
            imask_r <= prl_pkg::INT_RESET;
        end else if (wr_acc) begin
            if (paddr == prl_pkg::OFF_CTRL) begin
                ctrl_r <= pwdata[prl_pkg::CTRL_W-1:0];
            end
            if (paddr == prl_pkg::OFF_REPORT) begin
                rpt_r <= pwdata[prl_pkg::RPT_W-1:0];
            end
            if (paddr == prl_pkg::OFF_INT_MASK) begin
                imask_r <= pwdata[prl_pkg::INT_W-1:0];
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ist_r <= prl_pkg::INT_RESET;
        end else if (wr_acc && paddr == prl_pkg::OFF_INT_STAT) begin
            ist_r <= (ist_r & ~pwdata[prl_pkg::INT_W-1:0]) | ev;
        end else begin
            ist_r <= ist_r | ev;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= '0;
            irq_r <= 1'b0;
        end else begin
            pready_r <= acc;
            pslverr_r <= acc && !mapped;
            irq_r <= |(ist_r & imask_r);
            prdata_r <= '0;
            if (acc && !pwrite) begin
                unique case (paddr)
                    prl_pkg::OFF_CTRL: prdata_r <= 32'(ctrl_r);
                    prl_pkg::OFF_STATUS: prdata_r <= 32'({tx_st_r != prl_pkg::PRL_TX_FLAG,
                        pay_on, pay_st_r == prl_pkg::PRL_LP_PREP,
                        line_on, line_st_r == prl_pkg::PRL_LP_PREP});
                    prl_pkg::OFF_REPORT: prdata_r <= 32'(rpt_r);
                    prl_pkg::OFF_INT_STAT: prdata_r <= 32'(ist_r);
                    prl_pkg::OFF_INT_MASK: prdata_r <= 32'(imask_r);
                    default: prdata_r <= '0;
                endcase
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign irq = irq_r;
    assign line_tx_bit = line_tx_r;
    assign fwd_bit = fwd_r;
    assign dl_bit = dl_r;
    assign line_loop = line_on;
    assign payload_loop = pay_on;
endmodule : prl_maint

/* prl_pkg.sv */
// Shared constants for the primary rate report and loopback block
package prl_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_REPORT = 12'h008;
    localparam logic [11:0] OFF_INT_STAT = 12'h00C;
    localparam logic [11:0] OFF_INT_MASK = 12'h010;
    localparam int CTRL_SRC_SIDE = 0;
    localparam int CTRL_SECTION = 1;
    localparam int CTRL_LINE_EN = 2;
    localparam int CTRL_PAY_EN = 3;
    localparam int CTRL_RPT_EN = 4;
    localparam int CTRL_W = 5;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
    localparam int INT_LINE_UP = 0;
    localparam int INT_PAY_UP = 1;
    localparam int INT_RELEASE = 2;
    localparam int INT_SENT = 3;
    localparam int INT_W = 4;
    localparam logic [INT_W-1:0] INT_RESET = 4'h0;
    localparam int RPT_W = 16;
    localparam logic [RPT_W-1:0] RPT_RESET = 16'h0000;
    localparam int RPT_LB_POS = 11;
    localparam int RPT_N_LO = 8;
    localparam logic [7:0] FLAG_PAT = 8'h7E;
    localparam logic [5:0] SERVICE_POINT_ID_VAL = 6'h0E;
    localparam logic [7:0] CTL_UI = 8'h03;
    localparam logic [15:0] CRC_POLY = 16'h8408;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam int RPT_OCTETS = 12;
    localparam int STUFF_RUN = 5;
    localparam logic [7:0] IDLE_GAP = 8'h08;
    localparam logic [7:0] RPT_GAP_MIN = 8'h70;
    localparam logic [7:0] RPT_GAP_MAX = 8'h73;
    typedef enum logic [1:0] {PRL_TX_FLAG, PRL_TX_BODY, PRL_TX_FCS} prl_tx_e;
    typedef enum logic [1:0] {PRL_LP_OFF, PRL_LP_PREP, PRL_LP_ON} prl_lp_e;
endpackage : prl_pkg

/* prl_cw_if.sv */
// Bit feed and detection result between the maintenance core and a codeword detector
`timescale 1ns/100ps
interface prl_cw_if;
    logic bit_v;
    logic bit_d;
    logic hit;
    modport det (input bit_v, input bit_d, output hit);
    modport mon (output bit_v, output bit_d, input hit);
endinterface : prl_cw_if

/* prl_cw_detect.sv */
// Repeating codeword detector on the received line bit stream
`timescale 1ns/100ps
module prl_cw_detect #(
    parameter int LEN = 5,
    parameter logic [15:0] CODE = 16'h0001,
    parameter int HITS = 64
) (
    input wire logic clock,
    input wire logic rstn,
    prl_cw_if.det cw
);
    generate
        if (LEN < 1 || LEN > 16 || HITS < 1 || HITS > 65535) begin : g_bad
            $error("prl_cw_detect parameters out of range");
        end
    endgenerate

    logic [LEN-1:0] hist_r;
    logic [LEN-1:0] win;
    logic [15:0] run_r;
    logic hit_r;
    logic in_code;

    // Cast keeps the newest LEN bits, so a one-bit code needs no slice
    assign win = LEN'({hist_r, cw.bit_d});

    // Window must be some rotation of the codeword, not just any periodic pattern
    always_comb begin
        in_code = 1'b0;
        for (int k = 0; k < LEN; k++) begin
            if (win == LEN'((CODE[LEN-1:0] << k) |
                (CODE[LEN-1:0] >> (LEN - k)))) begin
                in_code = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            hist_r <= '0;
        end else if (cw.bit_v) begin
            hist_r <= win;
        end
    end

    // Any single miss drops detection; no error tolerance is offered
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            run_r <= 16'h0000;
            hit_r <= 1'b0;
        end else if (cw.bit_v) begin
            if (in_code) begin
                if (run_r != 16'(HITS)) begin
                    run_r <= run_r + 16'h0001;
                end
            end else begin
                run_r <= 16'h0000;
            end
            hit_r <= in_code && (run_r >= 16'(HITS - 1));
        end
    end

    assign cw.hit = hit_r;
endmodule : prl_cw_detect

/* prl_maint_checker.sv */
// Port checker for the report and loopback block
`timescale 1ns/100ps
module prl_maint_checker (
    input wire logic clock,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic bit_stb,
    input wire logic rx_bit,
    input wire logic rx_fbit,
    input wire logic loc_bit,
    input wire logic line_tx_bit,
    input wire logic fwd_bit,
    input wire logic dl_req,
    input wire logic dl_bit,
    input wire logic line_loop,
    input wire logic payload_loop
);
    logic [2:0] ones_r;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    // Flags give six ones in a row, so seven means stuffing failed
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ones_r <= 3'h0;
        end else if ($past(dl_req)) begin
            ones_r <= dl_bit ? ones_r + {2'h0, ones_r != 3'h7} : 3'h0;
        end
    end
    a_ready_answer: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready too long");
    a_normal_path: assert property (!line_loop && !payload_loop && bit_stb |=>
        line_tx_bit == $past(loc_bit)) else $error("local bit not sent");
    a_line_return: assert property (line_loop && bit_stb |=> line_tx_bit == $past(rx_bit))
        else $error("line loop bit wrong");
    a_fwd_alarm: assert property (bit_stb |=>
        fwd_bit == ($past(line_loop) || $past(rx_bit))) else $error("forward bit wrong");
    a_pay_frame: assert property (payload_loop && bit_stb && rx_fbit |=>
        line_tx_bit == $past(loc_bit)) else $error("framing bit not local");
    a_pay_data: assert property (payload_loop && bit_stb && !rx_fbit |=>
        line_tx_bit == $past(rx_bit)) else $error("payload bit wrong");
    a_stuff_limit: assert property (ones_r != 3'h7)
        else $error("seven ones on link");
endmodule : prl_maint_checker
bind prl_maint prl_maint_checker u_chk (.*);

/* prl_line_peer.sv */
// Far-end data link model: pulls bits and rebuilds received frames
`timescale 1ns/100ps
module prl_line_peer (
    input wire logic clock,
    input wire logic rstn,
    input wire logic dl_bit,
    output logic dl_req
);
    logic [7:0] sh, cur;
    logic [7:0] frame[$], acc[$];
    int div = 0, ones = 0, nb = 0, nfr = 0;
    initial dl_req = 1'h0;
    // Steady pull every four cycles, bit taken once it has settled
    always @(posedge clock) begin
        div = rstn ? (div + 1) % 4 : 0;
        dl_req <= rstn && div == 1;
        if (div == 3) begin
            sh = {dl_bit, sh[7:1]};
            if (sh == 8'h7E) begin
                if (acc.size() > 2) begin
                    frame = acc;
                    nfr++;
                end
                acc.delete();
                nb = 0;
                ones = 0;
            end else if (ones == 5 && !dl_bit) begin
                ones = 0;
            end else begin
                cur[nb] = dl_bit;
                nb = (nb + 1) % 8;
                ones = dl_bit ? ones + 1 : 0;
                if (nb == 0) acc.push_back(cur);
            end
        end
    end
endmodule : prl_line_peer

/* prl_maint_test.sv */
// Self-checking bench: registers, loopbacks and report frames
`timescale 1ns/100ps
module prl_maint_test;
    logic clock = 1'h0, rstn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic bit_stb = 1'h0, rx_bit = 1'h0, rx_fbit = 1'h0, loc_bit = 1'h0, one_sec = 1'h0;
    logic dl_v = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, q;
    logic pready, pslverr, irq, line_tx_bit, fwd_bit, dl_req, dl_bit, line_loop, payload_loop;
    int error_cnt = 0, checked = 0, bn = 0, cyc = 0;
    prl_maint #(.CW_HITS(8), .AIS_HITS(8)) dut (.clock(clock), .rstn(rstn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .bit_stb(bit_stb), .rx_bit(rx_bit),
        .rx_fbit(rx_fbit), .loc_bit(loc_bit), .line_tx_bit(line_tx_bit), .fwd_bit(fwd_bit),
        .dl_req(dl_req), .dl_bit(dl_bit), .dl_rx_valid(dl_v), .dl_rx_bit(dl_bit),
        .one_sec(one_sec), .line_loop(line_loop), .payload_loop(payload_loop));
    prl_line_peer peer (.clock(clock), .rstn(rstn), .dl_bit(dl_bit), .dl_req(dl_req));
    initial forever #4 clock = ~clock;
    // Own link fed back as the received one, a bit once it has settled
    always @(posedge clock) dl_v <= dl_req;
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            wrap_up();
        end
    end
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clock);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1) begin
            error_cnt++;
            wrap_up();
        end
        q = pslverr ? prdata | 32'h00010000 : prdata;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    // Line bits on alternate cycles; framing slots only where asked
    task automatic line(input logic [15:0] pat, input int len, input int reps, input logic fb);
        for (int i = 0; i < len * reps; i++) begin
            @(posedge clock);
            bit_stb <= 1'h1;
            rx_bit <= pat[i % len];
            rx_fbit <= fb && i % 3 == 0;
            loc_bit <= bn[0] ^ bn[2];
            bn++;
            @(posedge clock);
            bit_stb <= 1'h0;
        end
        repeat (4) @(posedge clock);
    endtask : line
    task automatic rpt(input logic [15:0] word, input logic [7:0] a1, a2, input logic lb);
        int n0 = peer.nfr, k = 0;
        logic [15:0] c = 16'hFFFF;
        apb(1'h1, 12'h008, {16'h0000, word});
        one_sec <= 1'h1;
        @(posedge clock);
        one_sec <= 1'h0;
        while (peer.nfr == n0 && k < 5000) begin
            @(posedge clock);
            k++;
        end
        if (peer.nfr == n0) begin
            error_cnt++;
            wrap_up();
        end
        for (int i = 0; i < peer.frame.size(); i++) begin
            for (int j = 0; j < 8; j++) begin
                c = (c[0] ^ peer.frame[i][j]) ? (c >> 1) ^ 16'h8408 : c >> 1;
            end
        end
        chk("octets", 16'(peer.frame.size()), 16'h000D);
        chk("addr1", 16'(peer.frame[0]), 16'(a1));
        chk("addr2", 16'(peer.frame[1]), 16'(a2));
        chk("control", 16'(peer.frame[2]), 16'h0003);
        chk("word lo", 16'(peer.frame[3]), 16'(word[7:0]));
        chk("loop flag", 16'(peer.frame[4][3]), 16'(lb));
        chk("check", c, 16'hF0B8);
    endtask : rpt
    initial begin
        repeat (16) @(posedge clock);
        rstn <= 1'h1;
        apb(1'h0, 12'h014, 32'h00000000);
        chk("unmapped", q[16:1], 16'h8000);
        apb(1'h1, 12'h000, 32'h0000001F);
        apb(1'h1, 12'h010, 32'h0000000F);
        apb(1'h0, 12'h000, 32'h00000000);
        chk("ctrl", q[15:0], 16'h001F);
        line(16'h0001, 5, 4, 1'h0);
        apb(1'h0, 12'h004, 32'h00000000);
        chk("prepare", {q[15:2], line_loop, q[0]}, 16'h0001);
        line(16'h0006, 4, 3, 1'h0);
        chk("engaged", {14'h0000, line_loop, fwd_bit}, 16'h0003);
        apb(1'h0, 12'h00C, 32'h00000000);
        chk("irq up", {q[0], 15'(irq)}, 16'h8001);
        apb(1'h1, 12'h010, 32'h00000000);
        repeat (2) @(posedge clock);
        chk("irq masked", 16'(irq), 16'h0000);
        apb(1'h1, 12'h00C, 32'h0000000F);
        apb(1'h1, 12'h010, 32'h0000000F);
        repeat (2) @(posedge clock);
        chk("irq clear", 16'(irq), 16'h0000);
        line(16'h0001, 1, 12, 1'h0);
        chk("ais release", 16'(line_loop), 16'h0000);
        line(16'h0003, 6, 3, 1'h0);
        line(16'h0006, 4, 3, 1'h1);
        chk("payload", 16'(payload_loop), 16'h0001);
        rpt(16'h00A5, 8'h3A, 8'h03, 1'h1);
        rpt(16'h00A5, 8'h3A, 8'h03, 1'h1);
        repeat (2) @(posedge clock);
        chk("report release", 16'(payload_loop), 16'h0000);
        line(16'h0003, 6, 3, 1'h0);
        line(16'h0006, 4, 3, 1'h1);
        chk("payload again", 16'(payload_loop), 16'h0001);
        line(16'h0001, 3, 4, 1'h0);
        chk("code release", 16'(payload_loop), 16'h0000);
        apb(1'h1, 12'h000, 32'h00000010);
        rpt(16'h005A, 8'h38, 8'h01, 1'h0);
        wrap_up();
    end
endmodule : prl_maint_test
